// File: core/apr_pkg.sv
// Constants for the axis position, ring and external drive block
package apr_pkg;

  // ----------------------------------------------------------------
  // Register word offsets (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [3:0] APR_REG_CTRL    = 4'h0;
  localparam logic [3:0] APR_REG_RINGMAX = 4'h1;
  localparam logic [3:0] APR_REG_CMDPOS  = 4'h2;
  localparam logic [3:0] APR_REG_ENCPOS  = 4'h3;
  localparam logic [3:0] APR_REG_GAIN    = 4'h4;
  localparam logic [3:0] APR_REG_FIXCNT  = 4'h5;
  localparam logic [3:0] APR_REG_RATE    = 4'h6;
  localparam logic [3:0] APR_REG_SPEED   = 4'h7;
  localparam logic [3:0] APR_REG_MOVE    = 4'h8;
  localparam logic [3:0] APR_REG_STATUS  = 4'h9;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int APR_CTRL_RING  = 0;
  localparam int APR_CTRL_TRI   = 1;
  localparam int APR_CTRL_MODE0 = 2;
  localparam int APR_CTRL_STOP  = 4;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] APR_RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] APR_RST_RATE  = 32'h0000_0064;
  localparam int          APR_CLK_HZ    = 40000000;
  localparam logic [31:0] APR_CLK_HZ32  = 32'h0262_5A00;
  localparam logic [31:0] APR_HALF_PULSE = 32'h0000_0004;

  // External drive modes
  typedef enum logic [1:0] {
    APR_EXT_OFF  = 2'b00,
    APR_EXT_HAND = 2'b01,
    APR_EXT_FIX  = 2'b10,
    APR_EXT_CONT = 2'b11
  } apr_ext_t;

  // Pulse engine state
  typedef enum logic [1:0] {
    APR_ST_IDLE = 2'b00,
    APR_ST_HIGH = 2'b01,
    APR_ST_LOW  = 2'b10
  } apr_state_t;

endpackage

// File: core/apr_axis.sv
// One axis: position counters with ring mode and external pulse drive
`timescale 1ns/100ps
`default_nettype none

module apr_axis
  import apr_pkg::*;
#(
  parameter int ACC_STEP = 100
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // External inputs, active low triggers
  input  wire logic        extTrigPos_b,
  input  wire logic        extTrigNeg_b,
  input  wire logic        handwheelPulse,
  input  wire logic        encUp,
  input  wire logic        encDown,
  // Motor outputs
  output logic             pulsePos,
  output logic             pulseNeg,
  output logic             driving
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  wire logic rstn = rstSync_r;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Order: trigPos, trigNeg, handwheel, encUp, encDown
  logic [4:0] pinRaw;
  logic [4:0] sync1_r, sync2_r, sync3_r, pinState_r;
  logic [4:0] pinStateNxt;
  assign pinRaw = {encDown, encUp, handwheelPulse, extTrigNeg_b, extTrigPos_b};
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r    <= 5'h03;
      sync2_r    <= 5'h03;
      sync3_r    <= 5'h03;
      pinState_r <= 5'h03;
    end
    else
    begin
      sync1_r    <= pinRaw;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      pinState_r <= pinStateNxt;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : gAgree
      assign pinStateNxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : pinState_r[gi];
    end
  endgenerate
  wire logic fallPos = pinState_r[0] & ~pinStateNxt[0];
  wire logic fallNeg = pinState_r[1] & ~pinStateNxt[1];
  wire logic riseHand = ~pinState_r[2] & pinStateNxt[2];
  wire logic riseUp   = ~pinState_r[3] & pinStateNxt[3];
  wire logic riseDn   = ~pinState_r[4] & pinStateNxt[4];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0]  ctrl_r;
  logic [31:0] ringMax_r, cmdPos_r, encPos_r, gain_r, fixCnt_r, rate_r;
  logic [31:0] speed_r, remain_r, divCnt_r, period_r, curPeriod_r;
  logic        dirNeg_r, contRun_r, answered_r;
  apr_state_t  st_r;
  logic [31:0] rdMux;

  // no limit compare
  // Ring wrap never meets a limit check, since this block has none
  wire logic ringOn = ctrl_r[APR_CTRL_RING];
  wire logic triOn  = ctrl_r[APR_CTRL_TRI];
  wire apr_ext_t extMode = apr_ext_t'(ctrl_r[APR_CTRL_MODE0+1:APR_CTRL_MODE0]);

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = oldV;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = newV[b*8 +: 8];
    return r;
  endfunction

  // Ring-aware step; ring maximum treated as unsigned top value
  function automatic logic [31:0] stepCount(input logic [31:0] v, input logic up, input logic ring,
                                           input logic [31:0] maxV);
    logic [31:0] r;
    r = up ? v + 32'h0000_0001 : v - 32'h0000_0001;
    if (ring && up && v == maxV)
      r = 32'h0000_0000;
    else if (ring && !up && v == 32'h0000_0000)
      r = maxV;
    return r;
  endfunction

  wire logic busReq  = (read | write) & ~answered_r;
  wire logic wrStb   = write & busReq;
  wire logic rdStb   = read & busReq;
  wire logic wrCtrl  = wrStb && address == APR_REG_CTRL;
  wire logic wrMove  = wrStb && address == APR_REG_MOVE;
  wire logic [31:0] wdCtrl = mergeBytes({27'h0, ctrl_r}, writedata, byteenable);
  // stop bit drops every external mode
  wire logic extDisable = wrCtrl && (wdCtrl[APR_CTRL_STOP] ||
                          wdCtrl[APR_CTRL_MODE0+1:APR_CTRL_MODE0] == APR_EXT_OFF);

  // ----------------------------------------------------------------
  // Pulse engine decisions
  // ----------------------------------------------------------------
  wire logic idle     = (st_r == APR_ST_IDLE);
  wire logic startFix = idle && extMode == APR_EXT_FIX && fallPos && fixCnt_r != 32'h0;
  wire logic startHw  = idle && extMode == APR_EXT_HAND && riseHand && gain_r != 32'h0;
  wire logic startMv  = idle && wrMove && writedata != 32'h0;
  wire logic startCp  = extMode == APR_EXT_CONT && (fallPos || fallNeg);
  wire logic stopAll  = extDisable;
  wire logic emitEdge = (st_r == APR_ST_HIGH) && divCnt_r == 32'h0;
  wire logic endLow   = (st_r == APR_ST_LOW) && divCnt_r == 32'h0;
  wire logic lastOne  = !contRun_r && remain_r == 32'h1;
  wire logic [31:0] ratePeriod = (rate_r == 32'h0) ? APR_CLK_HZ32 : APR_CLK_HZ32 / rate_r;
  // fixed moves with prevention stay at base speed, else ramp
  wire logic [31:0] startPeriod = triOn ? ratePeriod : ratePeriod << 2;
  wire logic [31:0] rampPeriod  = (!triOn && curPeriod_r > ratePeriod + ACC_STEP[31:0])
                                  ? curPeriod_r - ACC_STEP[31:0] : ratePeriod;
  // Half period, floored so the high phase never gets too narrow
  function automatic logic [31:0] halfOf(input logic [31:0] p);
    return ((p >> 1) < APR_HALF_PULSE) ? APR_HALF_PULSE : (p >> 1);
  endfunction
  // Loads are one short: the zero count is the last cycle of a phase
  // Odd periods lose one clock, a limit of the symmetric split
  wire logic [31:0] halfPeriod  = halfOf(curPeriod_r) - 32'h1;
  wire logic [31:0] startPer    = (startCp || startHw) ? ratePeriod : startPeriod;
  wire logic [31:0] startHalf   = halfOf(startPer) - 32'h1;

  // Pulse engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r        <= APR_ST_IDLE;
      remain_r    <= APR_RST_WORD;
      divCnt_r    <= APR_RST_WORD;
      curPeriod_r <= APR_RST_WORD;
      dirNeg_r    <= 1'b0;
      contRun_r   <= 1'b0;
    end
    else if (stopAll)
    begin
      st_r      <= APR_ST_IDLE;
      contRun_r <= 1'b0;
      remain_r  <= APR_RST_WORD;
    end
    else if (startCp)
    begin
      st_r        <= APR_ST_HIGH;
      contRun_r   <= 1'b1;
      dirNeg_r    <= fallNeg & ~fallPos;
      curPeriod_r <= ratePeriod;
      divCnt_r    <= startHalf;
    end
    else if (startFix || startHw || startMv)
    begin
      st_r        <= APR_ST_HIGH;
      contRun_r   <= 1'b0;
      remain_r    <= startFix ? fixCnt_r : startHw ? gain_r : (writedata[31] ? -writedata : writedata);
      dirNeg_r    <= startMv ? writedata[31] : 1'b0;
      curPeriod_r <= startPer;
      divCnt_r    <= startHalf;
    end
    else if (!idle)
    begin
      divCnt_r <= divCnt_r - 32'h1;
      if (emitEdge)
      begin
        st_r     <= APR_ST_LOW;
        divCnt_r <= halfPeriod;
      end
      else if (endLow)
      begin
        curPeriod_r <= rampPeriod;
        divCnt_r    <= halfPeriod;
        if (lastOne)
          st_r <= APR_ST_IDLE;
        else
        begin
          st_r <= APR_ST_HIGH;
          if (!contRun_r)
            remain_r <= remain_r - 32'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters and register writes
  // ----------------------------------------------------------------
  wire logic outStep = emitEdge;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r     <= 5'h00;
      ringMax_r  <= APR_RST_WORD;
      cmdPos_r   <= APR_RST_WORD;
      encPos_r   <= APR_RST_WORD;
      gain_r     <= APR_RST_WORD;
      fixCnt_r   <= APR_RST_WORD;
      rate_r     <= APR_RST_RATE;
      speed_r    <= APR_RST_WORD;
      answered_r <= 1'b0;
      readdata   <= APR_RST_WORD;
      waitrequest <= 1'b1;
      pulsePos   <= 1'b0;
      pulseNeg   <= 1'b0;
      driving    <= 1'b0;
    end
    else
    begin
      answered_r  <= busReq;
      waitrequest <= ~busReq;
      pulsePos    <= (st_r == APR_ST_HIGH) && !dirNeg_r;
      pulseNeg    <= (st_r == APR_ST_HIGH) && dirNeg_r;
      driving     <= !idle;
      speed_r <= idle ? 32'h0 : APR_CLK_HZ32 / ((curPeriod_r == 32'h0) ? 32'h1 : curPeriod_r);
      // one ring flag for both counters
      if (wrStb && address == APR_REG_CMDPOS)
        cmdPos_r <= mergeBytes(cmdPos_r, writedata, byteenable);
      else if (outStep)
        cmdPos_r <= stepCount(cmdPos_r, !dirNeg_r, ringOn, ringMax_r);
      if (wrStb && address == APR_REG_ENCPOS)
        encPos_r <= mergeBytes(encPos_r, writedata, byteenable);
      else if (riseUp != riseDn)
        encPos_r <= stepCount(encPos_r, riseUp, ringOn, ringMax_r);
      if (wrCtrl)
        ctrl_r <= {1'b0, (wdCtrl[APR_CTRL_STOP] ? 2'h0 : wdCtrl[3:2]), wdCtrl[1:0]};
      if (wrStb && address == APR_REG_RINGMAX)
        ringMax_r <= mergeBytes(ringMax_r, writedata, byteenable);
      if (wrStb && address == APR_REG_GAIN)
        gain_r <= mergeBytes(gain_r, writedata, byteenable);
      if (wrStb && address == APR_REG_FIXCNT)
        fixCnt_r <= mergeBytes(fixCnt_r, writedata, byteenable);
      if (wrStb && address == APR_REG_RATE)
        rate_r <= mergeBytes(rate_r, writedata, byteenable);
      if (rdStb)
        readdata <= rdMux;
    end
  end

  // Read decode; unmapped words read zero
  always_comb
  begin
    case (address)
      APR_REG_CTRL:    rdMux = {27'h0, ctrl_r};
      APR_REG_RINGMAX: rdMux = ringMax_r;
      APR_REG_CMDPOS:  rdMux = cmdPos_r;
      APR_REG_ENCPOS:  rdMux = encPos_r;
      APR_REG_GAIN:    rdMux = gain_r;
      APR_REG_FIXCNT:  rdMux = fixCnt_r;
      APR_REG_RATE:    rdMux = rate_r;
      APR_REG_SPEED:   rdMux = speed_r;
      APR_REG_STATUS:  rdMux = {29'h0, contRun_r, dirNeg_r, !idle};
      default:         rdMux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ringUp;
    @(posedge clk) disable iff (!rstn)
    (ringOn && outStep && !dirNeg_r && cmdPos_r == ringMax_r && !(wrStb && address == APR_REG_CMDPOS))
      |=> cmdPos_r == 32'h0;
  endproperty
  a_ringUp: assert property (p_ringUp) else $error("ring up did not wrap");

  property p_ringDn;
    @(posedge clk) disable iff (!rstn)
    (ringOn && riseDn && !riseUp && encPos_r == 32'h0 && !(wrStb && address == APR_REG_ENCPOS))
      |=> encPos_r == $past(ringMax_r);
  endproperty
  a_ringDn: assert property (p_ringDn) else $error("ring down did not load max");

  property p_disable;
    @(posedge clk) disable iff (!rstn)
    extDisable |=> ##1 !pulsePos && !pulseNeg;
  endproperty
  a_disable: assert property (p_disable) else $error("drive survived disable");

  property p_fixStart;
    @(posedge clk) disable iff (!rstn)
    startFix && !stopAll && !startCp |=> st_r == APR_ST_HIGH ##1 driving;
  endproperty
  a_fixStart: assert property (p_fixStart) else $error("fixed burst not started");

  property p_cpNeg;
    @(posedge clk) disable iff (!rstn)
    startCp && fallNeg && !fallPos && !stopAll |=> dirNeg_r && contRun_r;
  endproperty
  a_cpNeg: assert property (p_cpNeg) else $error("negative continuous not started");

  property p_cpPos;
    @(posedge clk) disable iff (!rstn)
    startCp && fallPos && !stopAll |=> !dirNeg_r && contRun_r;
  endproperty
  a_cpPos: assert property (p_cpPos) else $error("positive continuous not started");

  property p_cmdWrite;
    @(posedge clk) disable iff (!rstn)
    wrStb && address == APR_REG_CMDPOS && byteenable == 4'hF |=> cmdPos_r == $past(writedata);
  endproperty
  a_cmdWrite: assert property (p_cmdWrite) else $error("command counter write lost");

  property p_linear;
    @(posedge clk) disable iff (!rstn)
    !ringOn && outStep && !dirNeg_r && !(wrStb && address == APR_REG_CMDPOS)
      |=> cmdPos_r == $past(cmdPos_r) + 32'h1;
  endproperty
  a_linear: assert property (p_linear) else $error("linear count wrong");

endmodule
`default_nettype wire

// File: testbench/apr_far_side.sv
// Far-side model: trigger pins, handwheel, encoder and a motor pulse counter
`timescale 1ns/100ps
`default_nettype none
module apr_far_side
(
  // Clock
  input  wire logic clk,
  // Motor pulses from the axis
  input  wire logic pulsePos,
  input  wire logic pulseNeg,
  // Pins toward the axis
  output logic      extTrigPos_b,
  output logic      extTrigNeg_b,
  output logic      handwheelPulse,
  output logic      encUp,
  output logic      encDown
);
  int   posCnt    = 0;
  int   negCnt    = 0;
  int   sinceEdge = 0;
  int   gaps[$];
  logic posDly    = 1'b0;
  logic negDly    = 1'b0;
  wire  anyRise   = (pulsePos & ~posDly) | (pulseNeg & ~negDly);

  initial
  begin
    extTrigPos_b = 1'b1;
    extTrigNeg_b = 1'b1;
    handwheelPulse = 1'b0;
    encUp = 1'b0;
    encDown = 1'b0;
  end

  // ----------------------------------------------------------------
  // Pulse counting, gap in clocks between successive pulses
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    posDly <= pulsePos;
    negDly <= pulseNeg;
    sinceEdge <= anyRise ? 1 : sinceEdge + 1;
    if (pulsePos && !posDly)
      posCnt <= posCnt + 1;
    if (pulseNeg && !negDly)
      negCnt <= negCnt + 1;
    if (anyRise)
      gaps.push_back(sinceEdge);
  end

  // One pin event; held 7 clocks so the 3-flop filter sees each level
  task automatic strobe(input int pin);
    int i;
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      case (pin)
        0: extTrigPos_b <= i[0];
        1: extTrigNeg_b <= i[0];
        2: handwheelPulse <= !i[0];
        3: encUp <= !i[0];
        default: encDown <= !i[0];
      endcase
      repeat (6) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_apr_axis.sv
// Self-checking bench for one axis with its far-side model
`timescale 1ns/100ps
`default_nettype none
module tb_apr_axis;
  import apr_pkg::*;
  localparam int          ACC     = 10;
  localparam logic [31:0] RATE_HI = 32'h000F_4240;
  localparam int          FLAT    = APR_CLK_HZ / 1000000;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        extTrigPos_b, extTrigNeg_b, handwheelPulse, encUp, encDown;
  logic        pulsePos, pulseNeg, driving;
  int          num_errors = 0;
  int          n_tests = 0;
  logic [31:0] q, v, mx, c0;
  logic [3:0]  be;
  int          i, n, p0, m0;

  always #12.5 clk = ~clk;

  apr_axis #(.ACC_STEP(ACC)) DUT (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .extTrigPos_b(extTrigPos_b), .extTrigNeg_b(extTrigNeg_b), .handwheelPulse(handwheelPulse),
    .encUp(encUp), .encDown(encDown), .pulsePos(pulsePos), .pulseNeg(pulseNeg), .driving(driving));

  apr_far_side FAR (.clk(clk), .pulsePos(pulsePos), .pulseNeg(pulseNeg), .extTrigPos_b(extTrigPos_b),
    .extTrigNeg_b(extTrigNeg_b), .handwheelPulse(handwheelPulse), .encUp(encUp), .encDown(encDown));

  // ----------------------------------------------------------------
  // Expectations and checking
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_pos(logic [31:0] p, logic up, logic [31:0] top, logic ring);
    if (ring && up && p == top)
      return 32'h0;
    if (ring && !up && p == 32'h0)
      return top;
    return up ? p + 32'h1 : p - 32'h1;
  endfunction

  function automatic logic [31:0] ctrl(logic ring, logic flat, apr_ext_t m);
    return {27'h0, 1'b0, m, flat, ring};
  endfunction

  // Byte lanes with their enable set take the new byte
  function automatic logic [31:0] lanes(logic [31:0] o, logic [31:0] d, logic [3:0] en);
    for (int b = 0; b < 4; b++)
      if (en[b])
        o[b*8 +: 8] = d[b*8 +: 8];
    return o;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic ok(input logic c);
    check({31'h0, c}, 32'h1);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Avalon master: hold until waitrequest sampled low
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0);
    ok(k < 50);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  // Wait for np pulses, then for the engine to go idle if asked
  task automatic wait_pulses(input int np, input logic idle);
    int k;
    k = 0;
    while ((FAR.gaps.size() < np || (idle && driving !== 1'b0)) && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    ok(k < 20000);
  endtask

  task automatic move(input logic [31:0] cnt, input int np);
    FAR.gaps.delete();
    wr(APR_REG_MOVE, cnt);
    wait_pulses(np, 1'b1);
    check(FAR.gaps.size(), np);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(87700));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(APR_REG_CTRL, q);
    check(q, APR_RST_WORD);
    rd(APR_REG_RATE, q);
    check(q, APR_RST_RATE);
    wr(4'hF, $urandom);
    rd(4'hF, q);
    check(q, 32'h0);
    // ----------------------------------------------------------------
    // Full signed range on counters and ring maximum
    // ----------------------------------------------------------------
    for (i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h7FFF_FFFF : (i == 2) ? 32'h0 : $urandom;
      wr(APR_REG_CMDPOS, v);
      rd(APR_REG_CMDPOS, q);
      check(q, v);
      wr(APR_REG_ENCPOS, ~v);
      rd(APR_REG_ENCPOS, q);
      check(q, ~v);
      wr(APR_REG_RINGMAX, v);
      rd(APR_REG_RINGMAX, q);
      check(q, v);
    end
    // ----------------------------------------------------------------
    // Ring wrap on both counters, then linear again
    // ----------------------------------------------------------------
    // Partial byte lanes on the command counter
    v = $urandom;
    c0 = $urandom;
    be = 4'(1 + ($urandom % 14));
    wr(APR_REG_CMDPOS, v);
    byteenable <= be;
    wr(APR_REG_CMDPOS, c0);
    byteenable <= 4'hF;
    rd(APR_REG_CMDPOS, q);
    check(q, lanes(v, c0, be));
    mx = 32'h9 + ($urandom % 100);
    wr(APR_REG_RINGMAX, mx);
    wr(APR_REG_ENCPOS, mx);
    wr(APR_REG_CMDPOS, mx);
    wr(APR_REG_RATE, RATE_HI);
    wr(APR_REG_CTRL, ctrl(1'b1, 1'b1, APR_EXT_OFF));
    FAR.strobe(3);
    rd(APR_REG_ENCPOS, q);
    check(q, next_pos(mx, 1'b1, mx, 1'b1));
    FAR.strobe(4);
    rd(APR_REG_ENCPOS, q);
    check(q, next_pos(32'h0, 1'b0, mx, 1'b1));
    move(32'h1, 1);
    rd(APR_REG_CMDPOS, q);
    check(q, next_pos(mx, 1'b1, mx, 1'b1));
    move(32'hFFFF_FFFF, 1);
    rd(APR_REG_CMDPOS, q);
    check(q, mx);
    wr(APR_REG_CTRL, ctrl(1'b0, 1'b1, APR_EXT_OFF));
    wr(APR_REG_ENCPOS, 32'h0);
    FAR.strobe(4);
    rd(APR_REG_ENCPOS, q);
    check(q, next_pos(32'h0, 1'b0, mx, 1'b0));
    // ----------------------------------------------------------------
    // Flat profile against ramped start
    // ----------------------------------------------------------------
    move(32'h5, 5);
    check(FAR.gaps[1], FLAT);
    check(FAR.gaps[4], FLAT);
    wr(APR_REG_CTRL, ctrl(1'b0, 1'b0, APR_EXT_OFF));
    move(32'h5, 5);
    ok(FAR.gaps[1] > FLAT);
    // ----------------------------------------------------------------
    // Fixed bursts on back-to-back triggers, handwheel with gain
    // ----------------------------------------------------------------
    n = 1 + ($urandom % 4);
    wr(APR_REG_FIXCNT, n);
    wr(APR_REG_CTRL, ctrl(1'b0, 1'b1, APR_EXT_FIX));
    for (i = 1; i < 3; i++)
    begin
      rd(APR_REG_CMDPOS, c0);
      FAR.gaps.delete();
      FAR.strobe(0);
      wait_pulses(n, 1'b1);
      check(FAR.gaps.size(), n);
      rd(APR_REG_CMDPOS, q);
      check(q, c0 + n);
    end
    n = 1 + ($urandom % 3);
    wr(APR_REG_GAIN, n);
    wr(APR_REG_CTRL, ctrl(1'b0, 1'b1, APR_EXT_HAND));
    FAR.gaps.delete();
    FAR.strobe(2);
    wait_pulses(n, 1'b1);
    check(FAR.gaps.size(), n);
    // ----------------------------------------------------------------
    // Continuous drive each way, stopped by the disable bit
    // ----------------------------------------------------------------
    for (i = 0; i < 2; i++)
    begin
      wr(APR_REG_CTRL, ctrl(1'b0, 1'b1, APR_EXT_CONT));
      p0 = FAR.posCnt;
      m0 = FAR.negCnt;
      FAR.gaps.delete();
      FAR.strobe(i);
      wait_pulses(4, 1'b0);
      rd(APR_REG_SPEED, q);
      check(q, RATE_HI);
      check(FAR.gaps[2], FLAT);
      ok(i == 0 ? FAR.posCnt > p0 && FAR.negCnt == m0 : FAR.negCnt > m0 && FAR.posCnt == p0);
      // Second pass keeps the continuous mode code beside the stop bit
      wr(APR_REG_CTRL, (i == 0) ? 32'h0000_0010 : 32'h0000_001C);
      wait_pulses(0, 1'b1);
      FAR.gaps.delete();
      FAR.strobe(i);
      FAR.strobe(2);
      repeat (200) @(posedge clk);
      check(FAR.gaps.size(), 0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
